// file: design/fhc_ctrl.sv
// Host controller that drives a parallel boot-sector flash from APB registers
`timescale 1ns/1ps
`include "fhc_defs.svh"
module fhc_ctrl (
    input  wire logic        CLOCK,
    input  wire logic        ARST_N,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    output logic      [20:0] FLASH_ADDR,
    output logic      [15:0] FLASH_DQ_O,
    input  wire logic [15:0] FLASH_DQ_I,
    output logic      [15:0] FLASH_DQ_OE_N,
    output logic             FLASH_CE_N,
    output logic             FLASH_WE_N,
    output logic             FLASH_OE_N,
    output logic             FLASH_RESET_N,
    output logic             FLASH_BYTE_N,
    input  wire logic        FLASH_READY_BUSY
);
    import fhc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Command sequence table

    // Unlock addresses depend on bus width; byte mode uses the shifted form
    function automatic fhc_step_type seq_step(input fhc_op_type op,
                                              input logic [2:0]  idx,
                                              input logic        wm,
                                              input logic [20:0] a,
                                              input logic [15:0] d);
        logic [20:0]  u1;
        logic [20:0]  u2;
        fhc_step_type s;
        u1      = wm ? 21'h000555 : 21'h000AAA;
        u2      = wm ? 21'h0002AA : 21'h000555;
        s.last  = 1'b1;
        s.write = 1'b1;
        s.poll  = POLL_NONE;
        s.addr  = u1;
        s.data  = 16'h00F0;
        case (op)
            OP_PROGRAM: begin
                s.last = (idx == 3'h3);
                case (idx)
                    3'h0: s.data = 16'h00AA;
                    3'h1: begin s.addr = u2; s.data = 16'h0055; end
                    3'h2: s.data = 16'h00A0;
                    default: begin s.addr = a; s.data = d; s.poll = POLL_POLAR; end
                endcase
            end
            OP_ERASE_SECT, OP_ERASE_CHIP: begin
                s.last = (idx == 3'h5);
                case (idx)
                    3'h0, 3'h3: s.data = 16'h00AA;
                    3'h1, 3'h4: begin s.addr = u2; s.data = 16'h0055; end
                    3'h2: s.data = 16'h0080;
                    default: begin
                        s.poll = POLL_TOGGLE;
                        if (op == OP_ERASE_SECT) begin
                            s.addr = a;
                            s.data = 16'h0030;
                        end else begin
                            s.data = 16'h0010;
                        end
                    end
                endcase
            end
            OP_BYP_ENTER: begin
                s.last = (idx == 3'h2);
                case (idx)
                    3'h0: s.data = 16'h00AA;
                    3'h1: begin s.addr = u2; s.data = 16'h0055; end
                    default: s.data = 16'h0020;
                endcase
            end
            OP_BYP_PROGRAM: begin
                s.last = (idx == 3'h1);
                if (idx == 3'h0) begin
                    s.data = 16'h00A0;
                end else begin
                    s.addr = a;
                    s.data = d;
                    s.poll = POLL_POLAR;
                end
            end
            OP_BYP_EXIT: begin
                s.last = (idx == 3'h1);
                s.data = (idx == 3'h0) ? 16'h0090 : 16'h0000;
            end
            OP_SUSPEND: begin
                s.addr = a;
                s.data = 16'h00B0;
                s.poll = POLL_TOGGLE;
            end
            OP_RESUME: begin
                s.addr = a;
                s.data = 16'h0030;
            end
            OP_CFI: begin
                s.addr = wm ? 21'h000055 : 21'h0000AA;
                s.data = 16'h0098;
            end
            OP_RESET_CMD: s.data = 16'h00F0;
            default: begin
                s.write = 1'b0;
                s.addr  = a;
            end
        endcase
        return s;
    endfunction : seq_step

    ////////////////////////////////////////////////////////////////////////////
    // State

    fhc_state_type st_q;
    fhc_op_type    op_q;
    logic          word_q;
    logic          pdata_q;
    logic [20:0]   addr_q;
    logic [15:0]   wdata_q;
    logic [15:0]   rdata_q;
    logic          done_q;
    logic          fail_q;
    logic          susp_q;
    logic          byp_q;
    logic [2:0]    idx_q;
    logic [7:0]    cnt_q;
    logic          poll_rd_q;
    logic          have_prev_q;
    logic [6:5]    prev_q;
    logic          pready_q;
    logic [31:0]   prdata_q;
    logic          pslverr_q;
    logic [15:0]   dq_s;
    logic          ready_s;

    // Data lines and ready/busy come from the flash's own timing domain
    fhc_sync #(.WIDTH(17)) u_sync (
        .clk    (CLOCK),
        .arst_n (ARST_N),
        .din    ({FLASH_READY_BUSY, FLASH_DQ_I}),
        .dout   ({ready_s, dq_s})
    );

    ////////////////////////////////////////////////////////////////////////////
    // APB decode

    wire          apb_setup = PSEL & PENABLE & ~pready_q;
    wire          apb_done  = PSEL & PENABLE & pready_q;
    wire          wr_ctrl   = apb_done & PWRITE & (PADDR == `FHC_REG_CTRL);
    wire          wr_addr   = apb_done & PWRITE & (PADDR == `FHC_REG_ADDR);
    wire          wr_wdata  = apb_done & PWRITE & (PADDR == `FHC_REG_WDATA);
    wire          wr_stat   = apb_done & PWRITE & (PADDR == `FHC_REG_STATUS);
    wire          idle      = (st_q == ST_IDLE);
    wire          go        = wr_ctrl & PWDATA[`FHC_CTRL_GO] & idle;
    wire fhc_op_type go_op  = fhc_op_type'(PWDATA[`FHC_CTRL_OP_MSB:`FHC_CTRL_OP_LSB]);
    // Erase while suspended, bypass program outside bypass mode and resume without a suspend are refused up front
    wire          go_bad    = ((go_op == OP_ERASE_SECT || go_op == OP_ERASE_CHIP) & susp_q)
                            | ((go_op == OP_BYP_PROGRAM) & ~byp_q)
                            | ((go_op == OP_RESUME) & ~susp_q);
    wire          mapped    = (PADDR == `FHC_REG_CTRL) | (PADDR == `FHC_REG_ADDR)
                            | (PADDR == `FHC_REG_WDATA) | (PADDR == `FHC_REG_RDATA)
                            | (PADDR == `FHC_REG_STATUS);
    wire   [31:0] status_w  = {26'h0, ready_s, byp_q, susp_q, fail_q, done_q, ~idle};
    wire   [31:0] ctrl_w    = {25'h0, pdata_q, word_q, 1'b0, op_q};
    wire   [31:0] rd_mux    = (PADDR == `FHC_REG_CTRL)   ? ctrl_w :
                              (PADDR == `FHC_REG_ADDR)   ? {11'h0, addr_q} :
                              (PADDR == `FHC_REG_WDATA)  ? {16'h0, wdata_q} :
                              (PADDR == `FHC_REG_RDATA)  ? {16'h0, rdata_q} :
                              (PADDR == `FHC_REG_STATUS) ? status_w : 32'h0;

    // One wait state: answer registered in the first access cycle
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            pready_q  <= 1'b0;
            prdata_q  <= 32'h0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q  <= apb_setup;
            prdata_q  <= (apb_setup & ~PWRITE) ? rd_mux : 32'h0;
            pslverr_q <= apb_setup & ~mapped;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer decode

    wire fhc_step_type step   = seq_step(op_q, idx_q, word_q, addr_q, wdata_q);
    wire          eff_write   = step.write & ~poll_rd_q;
    wire   [20:0] eff_addr    = poll_rd_q ? addr_q : step.addr;
    wire   [7:0]  strobe_len  = eff_write ? 8'(`FHC_WP_CYC)
                                          : 8'(`FHC_ACC_CYC + `FHC_SYNC_CYC);
    wire          strobe_end  = (cnt_q == strobe_len - 8'h01);
    // Toggle fails only on two bit 5 reads in a row: the first may already be array data
    wire          pol_ok      = (rdata_q[7] == wdata_q[7]);
    wire          tog_stop    = have_prev_q & (rdata_q[6] == prev_q[6]);
    wire          poll_ok     = (step.poll == POLL_POLAR) ? pol_ok : tog_stop;
    wire          poll_fail   = rdata_q[5] & (step.poll == POLL_POLAR | (have_prev_q & prev_q[5]));
    wire          finish      = (st_q == ST_HOLD & step.last & step.poll == POLL_NONE)
                              | (st_q == ST_HOLD & poll_rd_q & (poll_ok | poll_fail))
                              | (st_q == ST_POLL & ~pdata_q & ready_s
                                 & cnt_q >= 8'(`FHC_BUSY_CYC))
                              | (st_q == ST_RSTHI & cnt_q == 8'(`FHC_RH_CYC - 1));
    wire          op_fail     = (st_q == ST_HOLD) & poll_rd_q & ~poll_ok & poll_fail;

    ////////////////////////////////////////////////////////////////////////////
    // Software visible registers and sticky flags

    // Hardware set wins over a write-one-to-clear in the same cycle
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            op_q    <= OP_READ;
            word_q  <= 1'b1;
            pdata_q <= 1'b0;
            addr_q  <= 21'h0;
            wdata_q <= 16'h0;
            done_q  <= 1'b0;
            fail_q  <= 1'b0;
        end else begin
            if (wr_ctrl & idle) begin
                op_q    <= go_op;
                word_q  <= PWDATA[`FHC_CTRL_WORD];
                pdata_q <= PWDATA[`FHC_CTRL_PDATA];
            end
            if (wr_addr & idle)
                addr_q <= PWDATA[20:0];
            if (wr_wdata & idle)
                wdata_q <= PWDATA[15:0];
            done_q <= finish | (go & go_bad)
                    | (done_q & ~(wr_stat & PWDATA[`FHC_ST_DONE]));
            fail_q <= op_fail | (go & go_bad)
                    | (fail_q & ~(wr_stat & PWDATA[`FHC_ST_FAIL]));
        end
    end

    // Mode tracking follows each completed command
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            susp_q <= 1'b0;
            byp_q  <= 1'b0;
        end else if (finish & ~op_fail) begin
            case (op_q)
                OP_SUSPEND:    susp_q <= 1'b1;
                OP_RESUME:     susp_q <= 1'b0;
                OP_BYP_ENTER:  byp_q  <= 1'b1;
                OP_BYP_EXIT:   byp_q  <= 1'b0;
                OP_HW_RESET: begin
                    susp_q <= 1'b0;
                    byp_q  <= 1'b0;
                end
                default:       byp_q  <= byp_q;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus cycle sequencer

    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            st_q        <= ST_IDLE;
            idx_q       <= 3'h0;
            cnt_q       <= 8'h00;
            poll_rd_q   <= 1'b0;
            have_prev_q <= 1'b0;
            prev_q      <= 2'b00;
            rdata_q     <= 16'h0;
        end else begin
            cnt_q <= cnt_q + 8'h01;
            case (st_q)
                ST_IDLE: begin
                    idx_q       <= 3'h0;
                    poll_rd_q   <= 1'b0;
                    have_prev_q <= 1'b0;
                    cnt_q       <= 8'h00;
                    if (go & ~go_bad)
                        st_q <= (go_op == OP_HW_RESET) ? ST_RSTLO : ST_SETUP;
                end
                ST_SETUP: begin
                    cnt_q <= 8'h00;
                    st_q  <= ST_STROBE;
                end
                ST_STROBE: begin
                    if (strobe_end) begin
                        if (!eff_write)
                            rdata_q <= word_q ? dq_s : {8'h00, dq_s[7:0]};
                        st_q <= ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    cnt_q <= 8'h00;
                    if (poll_rd_q) begin
                        have_prev_q <= 1'b1;
                        prev_q      <= rdata_q[6:5];
                        st_q        <= (poll_ok | poll_fail) ? ST_IDLE : ST_SETUP;
                    end else if (!step.last) begin
                        idx_q <= idx_q + 3'h1;
                        st_q  <= ST_SETUP;
                    end else begin
                        st_q <= (step.poll == POLL_NONE) ? ST_IDLE : ST_POLL;
                    end
                end
                ST_POLL: begin
                    if (cnt_q >= 8'(`FHC_BUSY_CYC)) begin
                        cnt_q <= cnt_q;
                        if (pdata_q) begin
                            poll_rd_q <= 1'b1;
                            st_q      <= ST_SETUP;
                        end else if (ready_s) begin
                            st_q <= ST_IDLE;
                        end
                    end
                end
                ST_RSTLO: begin
                    if (cnt_q == 8'(`FHC_RP_CYC - 1)) begin
                        cnt_q <= 8'h00;
                        st_q  <= ST_RSTHI;
                    end
                end
                ST_RSTHI: begin
                    if (cnt_q == 8'(`FHC_RH_CYC - 1))
                        st_q <= ST_IDLE;
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Flash pins, all registered

    wire next_cyc = (st_q == ST_SETUP) | (st_q == ST_STROBE & ~strobe_end);

    // Chip select high between cycles keeps the device in standby; address is held
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            FLASH_ADDR    <= 21'h0;
            FLASH_DQ_O    <= 16'h0;
            FLASH_DQ_OE_N <= 16'hFFFF;
            FLASH_CE_N    <= 1'b1;
            FLASH_WE_N    <= 1'b1;
            FLASH_OE_N    <= 1'b1;
            FLASH_RESET_N <= 1'b1;
            FLASH_BYTE_N  <= 1'b0;
        end else begin
            FLASH_BYTE_N  <= word_q;
            FLASH_RESET_N <= ~(st_q == ST_RSTLO);
            FLASH_CE_N    <= ~((st_q == ST_SETUP) | (st_q == ST_STROBE));
            if (st_q == ST_SETUP) begin
                FLASH_ADDR    <= eff_addr;
                FLASH_DQ_O    <= step.data;
                FLASH_DQ_OE_N <= eff_write ? {~word_q ? 8'hFF : 8'h00, 8'h00} : 16'hFFFF;
            end else if (st_q == ST_HOLD) begin
                FLASH_DQ_OE_N <= 16'hFFFF;
            end
            // Strobes are exclusive so the flash never drives against us
            FLASH_WE_N <= ~(next_cyc & eff_write);
            FLASH_OE_N <= ~(next_cyc & ~eff_write);
        end
    end

    assign PREADY  = pready_q;
    assign PRDATA  = prdata_q;
    assign PSLVERR = pslverr_q;

endmodule : fhc_ctrl

// file: design/fhc_defs.svh
// Register map, field positions, reset values and timing counts of the flash host controller
`ifndef FHC_DEFS_SVH
`define FHC_DEFS_SVH

// Register byte offsets on APB
`define FHC_REG_CTRL    8'h00
`define FHC_REG_ADDR    8'h04
`define FHC_REG_WDATA   8'h08
`define FHC_REG_RDATA   8'h0C
`define FHC_REG_STATUS  8'h10

// Control register fields
`define FHC_CTRL_OP_LSB 0
`define FHC_CTRL_OP_MSB 3
`define FHC_CTRL_GO     4
`define FHC_CTRL_WORD   5
`define FHC_CTRL_PDATA  6
`define FHC_CTRL_RST    3'h1

// Status register fields
`define FHC_ST_BUSY     0
`define FHC_ST_DONE     1
`define FHC_ST_FAIL     2
`define FHC_ST_SUSP     3
`define FHC_ST_BYP      4
`define FHC_ST_READY    5

// Timing, in ns as printed, and derived clock counts (least times round up)
`define FHC_CLK_NS      25
`define FHC_CYC(ns)     (((ns) + `FHC_CLK_NS - 1) / `FHC_CLK_NS)
`define FHC_T_WP_NS     35
`define FHC_T_ACC_NS    70
`define FHC_T_BUSY_NS   90
`define FHC_T_RP_NS     500
`define FHC_T_RH_NS     50
`define FHC_WP_CYC      `FHC_CYC(`FHC_T_WP_NS)
`define FHC_ACC_CYC     `FHC_CYC(`FHC_T_ACC_NS)
`define FHC_BUSY_CYC    `FHC_CYC(`FHC_T_BUSY_NS)
`define FHC_RP_CYC      `FHC_CYC(`FHC_T_RP_NS)
`define FHC_RH_CYC      `FHC_CYC(`FHC_T_RH_NS)
`define FHC_SYNC_CYC    2

`endif

// file: design/fhc_pkg.sv
// Types shared by the flash host controller
package fhc_pkg;

    typedef enum logic [3:0] {
        OP_READ        = 4'h0,
        OP_PROGRAM     = 4'h1,
        OP_ERASE_SECT  = 4'h2,
        OP_ERASE_CHIP  = 4'h3,
        OP_SUSPEND     = 4'h4,
        OP_RESUME      = 4'h5,
        OP_RESET_CMD   = 4'h6,
        OP_HW_RESET    = 4'h7,
        OP_CFI         = 4'h8,
        OP_BYP_ENTER   = 4'h9,
        OP_BYP_PROGRAM = 4'hA,
        OP_BYP_EXIT    = 4'hB
    } fhc_op_type;

    typedef enum logic [1:0] {
        POLL_NONE   = 2'h0,
        POLL_POLAR  = 2'h1,
        POLL_TOGGLE = 2'h2
    } fhc_poll_type;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_SETUP  = 3'b001,
        ST_STROBE = 3'b011,
        ST_HOLD   = 3'b010,
        ST_POLL   = 3'b110,
        ST_RSTLO  = 3'b111,
        ST_RSTHI  = 3'b101
    } fhc_state_type;

    typedef struct packed {
        logic         last;
        logic         write;
        fhc_poll_type poll;
        logic [20:0]  addr;
        logic [15:0]  data;
    } fhc_step_type;

endpackage : fhc_pkg

// file: design/fhc_sync.sv
// Two-flop synchroniser bank for pins sampled from the flash
`timescale 1ns/1ps
module fhc_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             arst_n,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta_q;

    // First stage feeds only the second stage
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_q <= '0;
            dout   <= '0;
        end else begin
            meta_q <= din;
            dout   <= meta_q;
        end
    end
endmodule : fhc_sync

// file: verif/fhc_flash_model.sv
// Behavioural parallel flash that answers the controller's pins
`timescale 1ns/1ps
module fhc_flash_model #(
    parameter int BUSY_NS = 2000
) (
    input  wire logic [20:0] addr,
    input  wire logic [15:0] dq_o,
    input  wire logic        ce_n,
    input  wire logic        we_n,
    input  wire logic        oe_n,
    input  wire logic        reset_n,
    output logic      [15:0] dq_i,
    output logic             ready_busy
);
    logic [15:0] mem [int];
    logic [15:0] rd_q  = 16'hFFFF, dat_q = 16'hFFFF;
    logic        prog  = 1'b0;
    int          wcnt  = 0;
    // Flat unprotected array, no query table
    initial ready_busy = 1'b1;
    // Drives only when selected and strobed; otherwise the last word inverted
    assign dq_i = (!ce_n && !oe_n) ? rd_q : ~rd_q;
    // Write strobe latches address and data; simple decoder, writes ignored while busy
    always @(posedge we_n) begin
        if (!ce_n && reset_n && ready_busy) begin
            wcnt = (dq_o[7:0] == 8'hF0 && !(prog && wcnt == 3)) ? 0 : wcnt + 1;
            if (wcnt == 3)
                prog = (dq_o[7:0] == 8'hA0);
            if ((wcnt == 4 && prog) || wcnt == 6) begin
                if (prog)
                    mem[addr] = dq_o;
                else
                    mem.delete();
                dat_q = prog ? dq_o : 16'hFFFF;
                ready_busy = 1'b0;
                wcnt = 0;
            end
        end
    end
    // Self-timed operation; ready pin rises when time runs out
    always begin
        wait (!ready_busy);
        #(BUSY_NS);
        ready_busy = 1'b1;
    end
    // Reset pin aborts the operation and any half-entered sequence
    always @(negedge reset_n) begin
        ready_busy = 1'b1;
        wcnt = 0;
    end
    // Status word while busy, with a toggling bit; array word otherwise
    always @(negedge oe_n) begin
        if (!ready_busy)
            rd_q = {8'h00, ~dat_q[7], ~rd_q[6], 6'h00};
        else
            rd_q = mem.exists(addr) ? mem[addr] : 16'hFFFF;
    end
endmodule : fhc_flash_model

// file: verif/fhc_ctrl_asserts.sv
// Port-level checks of the flash host controller
`timescale 1ns/1ps
module fhc_ctrl_asserts (
    input wire logic        CLOCK,
    input wire logic        ARST_N,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PREADY,
    input wire logic [20:0] FLASH_ADDR,
    input wire logic [15:0] FLASH_DQ_OE_N,
    input wire logic        FLASH_CE_N,
    input wire logic        FLASH_WE_N,
    input wire logic        FLASH_OE_N,
    input wire logic        FLASH_RESET_N
);
    logic [4:0] rst_lo_q;
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!ARST_N);
    // Cycles the reset pin has stayed low; cleared as soon as it is high
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N)
            rst_lo_q <= 5'h00;
        else
            rst_lo_q <= FLASH_RESET_N ? 5'h00 : rst_lo_q + 5'h01;
    end
    property p_oe_ce; !FLASH_OE_N |-> !FLASH_CE_N; endproperty
    a_oe_ce: assert property (p_oe_ce)
        else $error("output strobe without chip select");
    property p_we_excl; !FLASH_WE_N |-> FLASH_OE_N && !FLASH_CE_N; endproperty
    a_we_excl: assert property (p_we_excl)
        else $error("write strobe with output strobe or without select");
    property p_rd_free; !FLASH_OE_N |-> FLASH_DQ_OE_N == 16'hFFFF; endproperty
    a_rd_free: assert property (p_rd_free)
        else $error("data lines driven during a read");
    property p_we_len; $fell(FLASH_WE_N) |=> !FLASH_WE_N ##1 FLASH_WE_N; endproperty
    a_we_len: assert property (p_we_len)
        else $error("write strobe not two cycles");
    property p_we_drv; !FLASH_WE_N |-> FLASH_DQ_OE_N[7:0] == 8'h00; endproperty
    a_we_drv: assert property (p_we_drv)
        else $error("write data not driven");
    property p_idle_addr; FLASH_CE_N |-> $stable(FLASH_ADDR); endproperty
    a_idle_addr: assert property (p_idle_addr)
        else $error("address moved while deselected");
    property p_oe_len; $fell(FLASH_OE_N) |=> !FLASH_OE_N [*4] ##1 FLASH_OE_N; endproperty
    a_oe_len: assert property (p_oe_len)
        else $error("output strobe not five cycles");
    property p_apb_wait; PSEL && $rose(PENABLE) |-> !PREADY ##1 PREADY ##1 !PREADY; endproperty
    a_apb_wait: assert property (p_apb_wait)
        else $error("ready not one cycle after one wait state");
    property p_rst_len; $rose(FLASH_RESET_N) |-> rst_lo_q == 5'h14; endproperty
    a_rst_len: assert property (p_rst_len)
        else $error("reset pulse not twenty cycles");
endmodule : fhc_ctrl_asserts
bind fhc_ctrl fhc_ctrl_asserts fhc_ctrl_asserts_inst (.CLOCK(CLOCK), .ARST_N(ARST_N),
    .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY), .FLASH_ADDR(FLASH_ADDR),
    .FLASH_DQ_OE_N(FLASH_DQ_OE_N), .FLASH_CE_N(FLASH_CE_N), .FLASH_WE_N(FLASH_WE_N),
    .FLASH_OE_N(FLASH_OE_N), .FLASH_RESET_N(FLASH_RESET_N));

// file: verif/tb_fhc_ctrl.sv
// Self-checking bench for the flash host controller
`timescale 1ns/1ps
`define TB_CHK(nm, e, s) begin \
    compares++; \
    if ((s) !== (e)) begin num_errors++; $display("BAD %s exp %h got %h", nm, e, s); end \
end
module tb_fhc_ctrl;
    import fhc_pkg::*;
    logic        CLOCK = 1'b0, ARST_N = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
    logic [7:0]  PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0, PRDATA, rdat;
    logic        PREADY, PSLVERR, FLASH_CE_N, FLASH_WE_N, FLASH_OE_N, FLASH_RESET_N;
    logic        FLASH_BYTE_N, FLASH_READY_BUSY, wm = 1'b1, pd = 1'b0, chk = 1'b0, we_q = 1'b1;
    logic [20:0] FLASH_ADDR, a, u1, u2;
    logic [15:0] FLASH_DQ_O, FLASH_DQ_I, FLASH_DQ_OE_N, d, oe;
    logic [64:0] rq[$], rn;
    logic [53:0] wq[$];
    int          k, seed, num_errors = 0, compares = 0;
    wire  [53:0] pin_now = {FLASH_BYTE_N, FLASH_ADDR, FLASH_DQ_O | FLASH_DQ_OE_N, FLASH_DQ_OE_N};
    fhc_ctrl fhc_ctrl_inst (.CLOCK(CLOCK), .ARST_N(ARST_N), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .FLASH_ADDR(FLASH_ADDR), .FLASH_DQ_O(FLASH_DQ_O),
        .FLASH_DQ_I(FLASH_DQ_I), .FLASH_DQ_OE_N(FLASH_DQ_OE_N), .FLASH_CE_N(FLASH_CE_N),
        .FLASH_WE_N(FLASH_WE_N), .FLASH_OE_N(FLASH_OE_N), .FLASH_RESET_N(FLASH_RESET_N),
        .FLASH_BYTE_N(FLASH_BYTE_N), .FLASH_READY_BUSY(FLASH_READY_BUSY));
    fhc_flash_model fhc_flash_model_inst (.addr(FLASH_ADDR), .dq_o(FLASH_DQ_O),
        .ce_n(FLASH_CE_N), .we_n(FLASH_WE_N), .oe_n(FLASH_OE_N), .reset_n(FLASH_RESET_N),
        .dq_i(FLASH_DQ_I), .ready_busy(FLASH_READY_BUSY));
    initial forever #12.5 CLOCK = ~CLOCK;
    ////////////////////////////////////////////////////////////////////////////////////////
    // One APB transfer; request held until ready is sampled high
    task apb(input logic w, input logic [7:0] ad, input logic [31:0] wd, input logic c);
        @(posedge CLOCK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= ad;
        PWDATA <= wd;
        chk <= c;
        @(posedge CLOCK);
        PENABLE <= 1'b1;
        do @(posedge CLOCK); while (PREADY !== 1'b1);
        rdat = PRDATA;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask : apb
    task rd(input logic [7:0] ad, input logic [31:0] e, input logic [31:0] m, input logic er);
        rq.push_back({er, m, e & m});
        apb(1'b0, ad, 32'h0, 1'b1);
    endtask : rd
    // Expected flash write cycle; undriven data bits read as ones
    task pw(input logic [20:0] ad, input logic [15:0] wd);
        wq.push_back({wm, ad, wd | oe, oe});
    endtask : pw
    task unlock(input logic [15:0] c3);
        pw(u1, 16'h00AA);
        pw(u2, 16'h0055);
        pw(u1, c3);
    endtask : unlock
    // Start an op; optionally try an address write that busy must refuse
    task go(input fhc_op_type o, input logic j);
        apb(1'b1, 8'h00, {25'h0, pd, wm, 1'b1, o}, 1'b0);
        if (j)
            apb(1'b1, 8'h04, 32'h1555, 1'b0);
        do apb(1'b0, 8'h10, 32'h0, 1'b0); while (rdat[1] !== 1'b1);
    endtask : go
    task st(input logic [31:0] e);
        rd(8'h10, e, 32'hF, 1'b0);
        apb(1'b1, 8'h10, 32'h6, 1'b0);
    endtask : st
    task finish_test;
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : finish_test
    ////////////////////////////////////////////////////////////////////////////////////////
    // Result watcher: oldest note against each checked read and each pin write cycle
    always @(posedge CLOCK) begin
        we_q <= FLASH_WE_N;
        if (PSEL && PENABLE && PREADY === 1'b1 && chk) begin
            rn = rq.pop_front();
            `TB_CHK("apb", {rn[64], rn[31:0]}, {PSLVERR, PRDATA & rn[63:32]})
        end
        if (FLASH_WE_N === 1'b0 && we_q)
            `TB_CHK("pin", wq.pop_front(), pin_now)
    end
    initial begin
        #400000;
        num_errors++;
        finish_test();
    end
    // Word/byte and ready-pin/data polling in every combination, then erase and suspend
    initial begin
        seed = 13534;
        repeat (16) @(posedge CLOCK);
        ARST_N <= 1'b1;
        rd(8'h00, 32'h20, 32'h3F, 1'b0);
        rd(8'h10, 32'h20, 32'h3F, 1'b0);
        rd(8'h14, 32'h0, 32'h0, 1'b1);
        for (k = 0; k < 4; k++) begin
            wm = !k[1];
            pd = k[0];
            oe = wm ? 16'h0000 : 16'hFF00;
            u1 = wm ? 21'h555 : 21'hAAA;
            u2 = wm ? 21'h2AA : 21'h555;
            a = 21'($random(seed)) & 21'hFFFFF;
            d = 16'($random(seed));
            apb(1'b1, 8'h00, {25'h0, pd, wm, 5'h00}, 1'b0);
            apb(1'b1, 8'h04, 32'(a), 1'b0);
            apb(1'b1, 8'h08, 32'(d), 1'b0);
            unlock(16'h00A0);
            pw(a, d);
            go(OP_PROGRAM, 1'b1);
            st(32'h2);
            go(OP_READ, 1'b1);
            st(32'h2);
            rd(8'h0C, 32'(wm ? d : d & 16'h00FF), 32'hFFFF, 1'b0);
            rd(8'h04, 32'(a), 32'h1FFFFF, 1'b0);
        end
        for (k = 2; k < 4; k++) begin
            unlock(16'h0080);
            pw(u1, 16'h00AA);
            pw(u2, 16'h0055);
            pw(k == 2 ? a : u1, k == 2 ? 16'h0030 : 16'h0010);
            go(fhc_op_type'(k), 1'b0);
            st(32'h2);
            go(OP_READ, 1'b0);
            st(32'h2);
            rd(8'h0C, 32'h00FF, 32'hFFFF, 1'b0);
        end
        pw(a, 16'h00B0);
        go(OP_SUSPEND, 1'b0);
        st(32'hA);
        go(OP_ERASE_SECT, 1'b0);
        st(32'hE);
        pw(a, 16'h0030);
        go(OP_RESUME, 1'b0);
        st(32'h2);
        go(OP_RESUME, 1'b0);
        st(32'h6);
        go(OP_BYP_PROGRAM, 1'b0);
        st(32'h6);
        go(OP_HW_RESET, 1'b0);
        st(32'h2);
        finish_test();
    end
endmodule : tb_fhc_ctrl
